// >>> tac_consts.svh
// constants for the touch converter control block: offsets, fields, resets, timing
// assumed included by bare name from the control module
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

`define TAC_CTRL_OFFSET 8'h00
`define TAC_CTRL_RESET 16'h0000

`define TAC_BIT_PEN 15
`define TAC_BIT_STS 14
`define TAC_FUNC_HI 13
`define TAC_FUNC_LO 10
`define TAC_RES_HI 9
`define TAC_RES_LO 8
`define TAC_AVG_HI 7
`define TAC_AVG_LO 6
`define TAC_CLK_HI 5
`define TAC_CLK_LO 4
`define TAC_SET_HI 3
`define TAC_SET_LO 1

`define TAC_FUNC_NONE 4'h0
`define TAC_FUNC_XY 4'h1
`define TAC_FUNC_XYZ 4'h2
`define TAC_FUNC_DRV_X 4'hd
`define TAC_FUNC_DRV_Y 4'he
`define TAC_FUNC_DRV_YX 4'hf

`define TAC_RES_8 2'h1
`define TAC_RES_10 2'h2

`define TAC_CLK_MHZ 100
`define TAC_SETTLE1_US 100
`define TAC_SETTLE2_US 500
`define TAC_SETTLE3_US 1000
`define TAC_SETTLE4_US 5000
`define TAC_SETTLE5_US 10000
`define TAC_SETTLE6_US 50000
`define TAC_SETTLE7_US 100000

`define TAC_SLOT_X 4'h0
`define TAC_SLOT_Y 4'h1
`define TAC_SLOT_Z1 4'h2
`define TAC_SLOT_BAT1 4'h4
`define TAC_SLOT_BAT2 4'h5
`define TAC_SLOT_AUX1 4'h6
`define TAC_SLOT_AUX2 4'h7
`define TAC_SLOT_TEMP1 4'h8
`define TAC_SLOT_TEMP2 4'h9

`endif

// >>> tac_pkg.sv
// types shared by the touch converter control files
// assumes nothing beyond a SystemVerilog compiler
package tac_pkg;
  typedef enum logic [2:0] {
    TAC_IDLE = 3'b000,
    TAC_SETTLE = 3'b001,
    TAC_SAMPLE = 3'b010,
    TAC_WAIT = 3'b011,
    TAC_STORE = 3'b100
  } tac_state_e;
  typedef logic [3:0] tac_slot_t;
  typedef logic [15:0] tac_word_t;
endpackage

// >>> tac_mem_if.sv
// carrier between the control logic and its result memory
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface tac_mem_if;
  logic wrEn;
  tac_pkg::tac_slot_t wrAddr;
  tac_pkg::tac_word_t wrData;
  tac_pkg::tac_slot_t rdAddr;
  tac_pkg::tac_word_t rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

// >>> tac_result_mem.sv
// page-0 result store: one word per measurement slot, registered read
// assumes synchronous active-low reset and a single clock
`timescale 1ns/10ps
`default_nettype none
module tac_result_mem #(
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  tac_mem_if.mem port
);
  tac_pkg::tac_word_t store [DEPTH];
  tac_pkg::tac_word_t rdData_reg;
  tac_pkg::tac_word_t rdData_next;

  always_comb
  begin
    rdData_next = store[port.rdAddr];
  end

  always_ff @(posedge mclk)
  begin
    if (port.wrEn)
    begin
      store[port.wrAddr] <= port.wrData;
    end
    if (!rst_n)
    begin
      rdData_reg <= 16'h0000;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  assign port.rdData = rdData_reg;
endmodule
`default_nettype wire

// >>> tac_control.sv
// converter control register and scan sequencer of the touch converter
// assumes the host port decodes page and address into ctrlWrite
`timescale 1ns/10ps
`default_nettype none
`include "tac_consts.svh"
module tac_control #(
  parameter int unsigned SETTLE1_CYC = `TAC_SETTLE1_US * `TAC_CLK_MHZ,
  parameter int unsigned SETTLE2_CYC = `TAC_SETTLE2_US * `TAC_CLK_MHZ,
  parameter int unsigned SETTLE3_CYC = `TAC_SETTLE3_US * `TAC_CLK_MHZ,
  parameter int unsigned SETTLE4_CYC = `TAC_SETTLE4_US * `TAC_CLK_MHZ,
  parameter int unsigned SETTLE5_CYC = `TAC_SETTLE5_US * `TAC_CLK_MHZ,
  parameter int unsigned SETTLE6_CYC = `TAC_SETTLE6_US * `TAC_CLK_MHZ,
  parameter int unsigned SETTLE7_CYC = `TAC_SETTLE7_US * `TAC_CLK_MHZ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctrlWrite,
  input wire logic [15:0] ctrlWdata,
  output logic [15:0] ctrlRdata,
  input wire logic [3:0] resultAddr,
  output logic [15:0] resultData,
  input wire logic penDown,
  output logic adcStart,
  output logic [3:0] adcInput,
  output logic [1:0] adcClockSel,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  output logic [1:0] panelDrive,
  output logic adcPowerDown,
  output logic dataAvailable
);
  tac_mem_if memBus ();

  tac_result_mem #(.DEPTH(16)) resultMem (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(memBus)
  );

  tac_pkg::tac_state_e state_reg, state_next;
  logic scanMode_reg, scanMode_next;
  logic stop_reg, stop_next;
  logic [12:0] cfg_reg, cfg_next;
  logic [3:0] wrAddr_reg, wrAddr_next;
  logic [23:0] wait_reg, wait_next;
  logic [3:0] slot_reg, slot_next;
  logic [2:0] left_reg, left_next;
  logic [4:0] samples_reg, samples_next;
  logic [15:0] acc_reg, acc_next;
  logic [15:0] rd_reg, rd_next;
  logic start_reg, start_next;
  logic [1:0] drive_reg, drive_next;
  logic wrEn_reg, wrEn_next;
  logic [15:0] wrData_reg, wrData_next;

  logic [3:0] funcSel;
  logic [1:0] resSel;
  logic [1:0] avgSel;
  logic [2:0] setSel;
  logic [3:0] firstSlot;
  logic [2:0] slotCount;
  logic [4:0] avgTotal;
  logic [23:0] settleCyc;
  logic [11:0] sample;
  logic [15:0] averaged;
  logic busy;

  assign funcSel = cfg_reg[12:9];
  assign resSel = cfg_reg[8:7];
  assign avgSel = cfg_reg[6:5];
  assign setSel = cfg_reg[2:0];
  assign busy = (state_reg != tac_pkg::TAC_IDLE);

  // slot range per function code
  always_comb
  begin
    firstSlot = `TAC_SLOT_X;
    slotCount = 3'd0;
    unique case (funcSel)
      4'h1: begin firstSlot = `TAC_SLOT_X; slotCount = 3'd2; end
      4'h2: begin firstSlot = `TAC_SLOT_X; slotCount = 3'd4; end
      4'h3: begin firstSlot = `TAC_SLOT_X; slotCount = 3'd1; end
      4'h4: begin firstSlot = `TAC_SLOT_Y; slotCount = 3'd1; end
      4'h5: begin firstSlot = `TAC_SLOT_Z1; slotCount = 3'd2; end
      4'h6: begin firstSlot = `TAC_SLOT_BAT1; slotCount = 3'd1; end
      4'h7: begin firstSlot = `TAC_SLOT_BAT2; slotCount = 3'd1; end
      4'h8: begin firstSlot = `TAC_SLOT_AUX1; slotCount = 3'd1; end
      4'h9: begin firstSlot = `TAC_SLOT_AUX2; slotCount = 3'd1; end
      4'ha: begin firstSlot = `TAC_SLOT_TEMP1; slotCount = 3'd1; end
      4'hb: begin firstSlot = `TAC_SLOT_BAT1; slotCount = 3'd4; end
      4'hc: begin firstSlot = `TAC_SLOT_TEMP2; slotCount = 3'd1; end
      default: begin firstSlot = `TAC_SLOT_X; slotCount = 3'd0; end
    endcase
  end

  always_comb
  begin
    unique case (setSel)
      3'h0: settleCyc = 24'h000000;
      3'h1: settleCyc = 24'(SETTLE1_CYC);
      3'h2: settleCyc = 24'(SETTLE2_CYC);
      3'h3: settleCyc = 24'(SETTLE3_CYC);
      3'h4: settleCyc = 24'(SETTLE4_CYC);
      3'h5: settleCyc = 24'(SETTLE5_CYC);
      3'h6: settleCyc = 24'(SETTLE6_CYC);
      3'h7: settleCyc = 24'(SETTLE7_CYC);
    endcase
    unique case (avgSel)
      2'h0: avgTotal = 5'd1;
      2'h1: avgTotal = 5'd4;
      2'h2: avgTotal = 5'd8;
      2'h3: avgTotal = 5'd16;
    endcase
    unique case (avgSel)
      2'h0: averaged = acc_reg;
      2'h1: averaged = {2'h0, acc_reg[15:2]};
      2'h2: averaged = {3'h0, acc_reg[15:3]};
      2'h3: averaged = {4'h0, acc_reg[15:4]};
    endcase
    // truncate to the selected resolution, right aligned
    unique case (resSel)
      `TAC_RES_8: sample = {4'h0, adcData[11:4]};
      `TAC_RES_10: sample = {2'h0, adcData[11:2]};
      default: sample = adcData;
    endcase
  end

  always_comb
  begin
    logic newStart;
    logic selfStart;
    logic repeatScan;
    newStart = 1'b0;
    selfStart = 1'b0;
    repeatScan = 1'b0;
    state_next = state_reg;
    scanMode_next = scanMode_reg;
    stop_next = stop_reg;
    cfg_next = cfg_reg;
    wait_next = wait_reg;
    slot_next = slot_reg;
    left_next = left_reg;
    samples_next = samples_reg;
    acc_next = acc_reg;
    start_next = 1'b0;
    drive_next = drive_reg;
    wrEn_next = 1'b0;
    wrData_next = wrData_reg;
    if (ctrlWrite)
    begin
      scanMode_next = ctrlWdata[`TAC_BIT_PEN];
      stop_next = ctrlWdata[`TAC_BIT_STS];
      cfg_next = ctrlWdata[`TAC_FUNC_HI:`TAC_SET_LO];
      // a stop in the same write suppresses the start
      newStart = !ctrlWdata[`TAC_BIT_STS] && !ctrlWdata[`TAC_BIT_PEN];
    end
    selfStart = scanMode_reg && !stop_reg && penDown && !ctrlWrite;
    repeatScan = !stop_reg && penDown &&
      (funcSel == `TAC_FUNC_XY || funcSel == `TAC_FUNC_XYZ);
    unique case (state_reg)
      tac_pkg::TAC_IDLE:
      begin
        if (newStart || selfStart)
        begin
          if (ctrlWrite)
          begin
            slot_next = 4'h0;
            left_next = 3'd0;
          end
          state_next = tac_pkg::TAC_IDLE;
        end
      end
      tac_pkg::TAC_SETTLE:
      begin
        if (wait_reg == 24'h000000)
        begin
          state_next = tac_pkg::TAC_SAMPLE;
        end
        else
        begin
          wait_next = wait_reg - 24'h000001;
        end
      end
      tac_pkg::TAC_SAMPLE:
      begin
        start_next = 1'b1;
        state_next = tac_pkg::TAC_WAIT;
      end
      tac_pkg::TAC_WAIT:
      begin
        if (adcDone)
        begin
          acc_next = acc_reg + {4'h0, sample};
          samples_next = samples_reg + 5'd1;
          // stay busy through every averaged sample
          if (samples_reg + 5'd1 == avgTotal)
          begin
            state_next = tac_pkg::TAC_STORE;
          end
          else
          begin
            state_next = tac_pkg::TAC_SAMPLE;
          end
        end
      end
      tac_pkg::TAC_STORE:
      begin
        wrEn_next = 1'b1;
        wrData_next = averaged;
        acc_next = 16'h0000;
        samples_next = 5'd0;
        if (left_reg > 3'd1)
        begin
          left_next = left_reg - 3'd1;
          slot_next = slot_reg + 4'h1;
          state_next = tac_pkg::TAC_SETTLE;
          wait_next = settleCyc;
        end
        else if (repeatScan)
        begin
          left_next = slotCount;
          slot_next = firstSlot;
          state_next = tac_pkg::TAC_SETTLE;
          wait_next = settleCyc;
        end
        else
        begin
          left_next = 3'd0;
          state_next = tac_pkg::TAC_IDLE;
        end
      end
      default: state_next = tac_pkg::TAC_IDLE;
    endcase
    // take a freshly written setup on a start from idle; a pen self-start launches here with the held setup
    if (state_reg == tac_pkg::TAC_IDLE && (newStart || selfStart))
    begin
      if (ctrlWrite)
      begin
        cfg_next = ctrlWdata[`TAC_FUNC_HI:`TAC_SET_LO];
      end
    end
    if (state_reg == tac_pkg::TAC_IDLE && selfStart && slotCount != 3'd0)
    begin
      left_next = slotCount;
      slot_next = firstSlot;
      wait_next = settleCyc;
      state_next = tac_pkg::TAC_SETTLE;
    end
    // panel drivers for touch slots and for driver-only codes
    if (state_next != tac_pkg::TAC_IDLE)
    begin
      drive_next = (slot_next == `TAC_SLOT_X) ? 2'h1 :
        (slot_next == `TAC_SLOT_Y) ? 2'h2 : (slot_next < 4'h4) ? 2'h3 : 2'h0;
    end
    else
    begin
      unique case (cfg_next[12:9])
        `TAC_FUNC_DRV_X: drive_next = 2'h1;
        `TAC_FUNC_DRV_Y: drive_next = 2'h2;
        `TAC_FUNC_DRV_YX: drive_next = 2'h3;
        default: drive_next = 2'h0;
      endcase
    end
    if (stop_next)
    begin
      state_next = tac_pkg::TAC_IDLE;
      start_next = 1'b0;
      wrEn_next = 1'b0;
      drive_next = 2'h0;
      acc_next = 16'h0000;
      samples_next = 5'd0;
    end
    // live status in bits 15 and 14, written config echoed in bits 13:1
    rd_next = {penDown, !busy, cfg_reg, 1'b0};
    // store address frozen with the slot being stored
    wrAddr_next = slot_reg;
  end

  // host write start resolved after the write lands in the config
  logic hostGo_reg, hostGo_next;
  always_comb
  begin
    hostGo_next = ctrlWrite && !ctrlWdata[`TAC_BIT_STS] && !ctrlWdata[`TAC_BIT_PEN] &&
      ctrlWdata[`TAC_FUNC_HI:`TAC_FUNC_LO] != `TAC_FUNC_NONE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= tac_pkg::TAC_IDLE;
      scanMode_reg <= 1'b0;
      stop_reg <= 1'b0;
      cfg_reg <= 13'h0000;
      wrAddr_reg <= 4'h0;
      wait_reg <= 24'h000000;
      slot_reg <= 4'h0;
      left_reg <= 3'd0;
      samples_reg <= 5'd0;
      acc_reg <= 16'h0000;
      rd_reg <= 16'h4000;
      start_reg <= 1'b0;
      drive_reg <= 2'h0;
      wrEn_reg <= 1'b0;
      wrData_reg <= 16'h0000;
      hostGo_reg <= 1'b0;
    end
    else
    begin
      if (hostGo_reg && state_reg == tac_pkg::TAC_IDLE && !stop_reg && slotCount != 3'd0)
      begin
        state_reg <= tac_pkg::TAC_SETTLE;
        left_reg <= slotCount;
        slot_reg <= firstSlot;
        wait_reg <= settleCyc;
      end
      else
      begin
        state_reg <= state_next;
        left_reg <= left_next;
        slot_reg <= slot_next;
        wait_reg <= wait_next;
      end
      scanMode_reg <= scanMode_next;
      stop_reg <= stop_next;
      cfg_reg <= cfg_next;
      wrAddr_reg <= wrAddr_next;
      samples_reg <= samples_next;
      acc_reg <= acc_next;
      rd_reg <= rd_next;
      start_reg <= start_next;
      drive_reg <= drive_next;
      wrEn_reg <= wrEn_next;
      wrData_reg <= wrData_next;
      hostGo_reg <= hostGo_next;
    end
  end

  assign memBus.wrEn = wrEn_reg;
  assign memBus.wrAddr = wrAddr_reg;
  assign memBus.wrData = wrData_reg;
  assign memBus.rdAddr = resultAddr;
  assign resultData = memBus.rdData;
  assign ctrlRdata = rd_reg;
  assign adcStart = start_reg;
  assign adcInput = slot_reg;
  assign adcClockSel = cfg_reg[4:3];
  assign panelDrive = drive_reg;
  assign adcPowerDown = stop_reg;
  assign dataAvailable = rd_reg[`TAC_BIT_STS];
endmodule
`default_nettype wire

// >>> tac_control_monitor.sv
// assertion checker for the converter control block
// assumes binding onto tac_control: one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module tac_control_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctrlWrite,
  input wire logic [15:0] ctrlWdata,
  input wire logic [15:0] ctrlRdata,
  input wire logic penDown,
  input wire logic adcStart,
  input wire logic adcDone,
  input wire logic adcPowerDown,
  input wire logic dataAvailable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence stopWr;
    ctrlWrite && ctrlWdata[14];
  endsequence
  sequence idleWr;
    dataAvailable && ctrlWrite && ctrlWdata[15:10] == 6'h00;
  endsequence
  sequence halted;
    ##[1:3] (ctrlRdata[14] && dataAvailable && adcPowerDown);
  endsequence
  stop_halts_a: assert property (stopWr |=> halted)
    else $error("stop did not halt and power down");
  stop_no_start_a: assert property (stopWr |=> !adcStart [*4])
    else $error("conversion started after stop");
  func_zero_a: assert property (idleWr |=> !adcStart [*6])
    else $error("function zero started a conversion");
  pen_live_a: assert property (ctrlRdata[15] == $past(penDown))
    else $error("pen bit does not follow touch");
  reset_read_a: assert property ($rose(rst_n) |-> ctrlRdata == 16'h4000)
    else $error("wrong control read after reset");
  cfg_echo_a: assert property (ctrlWrite |=> ##1 ctrlRdata[13:1] == $past(ctrlWdata[13:1], 2)
    && !ctrlRdata[0])
    else $error("config read-back wrong");
  busy_start_a: assert property (adcStart |-> !dataAvailable && !ctrlRdata[14])
    else $error("start while reporting idle");
  avg_busy_a: assert property (adcDone && !dataAvailable |=> !dataAvailable)
    else $error("idle reported right after a conversion");
  single_start_a: assert property (adcStart |=> !adcStart [*2])
    else $error("second start too soon");
  power_up_a: assert property (ctrlWrite && !ctrlWdata[14] |=> ##[0:1] !adcPowerDown)
    else $error("converter left powered down");
endmodule
`default_nettype wire

// >>> tac_adc_model.sv
// behavioural converter answering the start pulses of the control block
// assumes one clock; latency in cycles comes from the bench, at least 1
`timescale 1ns/10ps
`default_nettype none
module tac_adc_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic adcStart,
  input wire logic [3:0] adcInput,
  input wire logic [3:0] latency,
  output logic adcDone,
  output logic [11:0] adcData
);
  logic [3:0] slotReg;
  logic [3:0] cntReg;
  logic runReg;
  always_ff @(posedge mclk)
  begin
    cntReg <= cntReg - 4'h1;
    adcDone <= 1'b0;
    // data only valid with done, otherwise it keeps toggling
    adcData <= ~adcData;
    if (!rst_n)
    begin
      runReg <= 1'b0;
      adcData <= 12'h000;
    end
    else if (adcStart)
    begin
      runReg <= 1'b1;
      cntReg <= latency;
      slotReg <= adcInput;
    end
    else if (runReg && cntReg == 4'h1)
    begin
      runReg <= 1'b0;
      adcDone <= 1'b1;
      adcData <= {slotReg, ~slotReg, 4'h9};
    end
  end
endmodule
`default_nettype wire

// >>> tac_control_bench.sv
// self-checking bench of the converter control block with a converter model
// assumes monitor and model files compiled first
`timescale 1ns/10ps
`default_nettype none
module tac_control_bench;
  logic mclk;
  logic rst_n;
  logic ctrlWrite;
  logic [15:0] ctrlWdata;
  logic [15:0] ctrlRdata;
  logic [3:0] resultAddr;
  logic [15:0] resultData;
  logic penDown;
  logic [1:0] adcClockSel;
  logic [1:0] panelDrive;
  logic adcStart;
  logic [3:0] adcInput;
  logic adcDone;
  logic [11:0] adcData;
  logic adcPowerDown;
  logic dataAvailable;
  logic [3:0] latency;
  logic chk = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [31:0] seed = 32'h5db3a890;
  logic [15:0] expQ[$];
  logic [15:0] seen;
  int nMismatch = 0;
  int samplesChecked = 0;
  int starts = 0;
  always #5 mclk = ~mclk;
  tac_control #(.SETTLE1_CYC(2), .SETTLE2_CYC(4), .SETTLE3_CYC(6), .SETTLE4_CYC(8),
    .SETTLE5_CYC(10), .SETTLE6_CYC(12), .SETTLE7_CYC(14)) dut (
    .mclk(mclk), .rst_n(rst_n), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
    .ctrlRdata(ctrlRdata), .resultAddr(resultAddr), .resultData(resultData),
    .penDown(penDown), .adcStart(adcStart), .adcInput(adcInput), .adcClockSel(adcClockSel),
    .adcDone(adcDone), .adcData(adcData), .panelDrive(panelDrive), .adcPowerDown(adcPowerDown),
    .dataAvailable(dataAvailable));
  tac_adc_model conv (.mclk(mclk), .rst_n(rst_n), .adcStart(adcStart), .adcInput(adcInput),
    .latency(latency), .adcDone(adcDone), .adcData(adcData));
  assign seen = sel == 2'h0 ? resultData : sel == 2'h1 ? ctrlRdata :
    sel == 2'h2 ? {10'h000, adcClockSel, panelDrive, ctrlRdata[15], adcPowerDown} :
    starts[15:0];
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] res_of(input logic [3:0] s, input logic [1:0] r);
    logic [11:0] d;
    d = {s, ~s, 4'h9};
    return r == 2'h1 ? {8'h00, d[11:4]} : r == 2'h2 ? {6'h00, d[11:2]} : {4'h0, d};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d, comparisons %0d", nMismatch, samplesChecked);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge mclk);
    ctrlWrite <= 1'b1;
    ctrlWdata <= d;
    @(posedge mclk);
    ctrlWrite <= 1'b0;
  endtask
  // read source: 0 result, 1 control, 2 clock select, panel drive, pen and power-down, 3 start count
  task automatic rd(input logic [1:0] s, input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    sel <= s;
    resultAddr <= a;
    expQ.push_back(e);
    @(posedge mclk);
    chk <= 1'b1;
    @(posedge mclk);
    chk <= 1'b0;
  endtask
  task automatic wait_idle;
    int i;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 3000 && dataAvailable !== 1'b1; i++)
      @(posedge mclk);
    if (dataAvailable !== 1'b1)
    begin
      nMismatch++;
      give_verdict();
    end
  endtask
  always @(posedge mclk)
  begin
    if (adcStart === 1'b1)
      starts <= starts + 1;
    if (chk)
      check(seen, expQ.pop_front());
  end
  initial
  begin
    logic [3:0] funcs[8] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc};
    logic [3:0] slots[8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    logic [15:0] w;
    int k;
    int s0;
    mclk = 1'b0;
    rst_n = 1'b0;
    ctrlWrite = 1'b0;
    ctrlWdata = 16'h0000;
    resultAddr = 4'h0;
    penDown = 1'b0;
    latency = 4'h1;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(2'h1, 4'h0, 16'h4000);
    for (k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      latency <= seed[3:0] | 4'h1;
      w = {2'b00, funcs[k], seed[12:4], seed[13]};
      wr(w);
      wait_idle();
      rd(2'h1, 4'h0, {2'b01, w[13:1], 1'b0});
      rd(2'h0, slots[k], res_of(slots[k], w[9:8]));
    end
    wr(16'h03fe);
    repeat (20) @(posedge mclk);
    rd(2'h1, 4'h0, 16'h43fe);
    rd(2'h0, 4'h9, res_of(4'h9, w[9:8]));
    latency <= 4'hf;
    s0 = starts;
    wr(16'h0c00);
    for (k = 0; k < 200 && starts == s0; k++)
      @(posedge mclk);
    wr(16'h5400);
    wait_idle();
    rd(2'h1, 4'h0, 16'h5400);
    rd(2'h2, 4'h0, 16'h0001);
    rd(2'h3, 4'h0, 16'(s0 + 1));
    latency <= 4'h2;
    penDown <= 1'b1;
    s0 = starts;
    wr(16'h8402);
    repeat (200) @(posedge mclk);
    check({14'h0000, ctrlRdata[15], adcPowerDown}, 16'h0002);
    check({15'h0000, starts > s0 + 4}, 16'h0001);
    penDown <= 1'b0;
    wait_idle();
    s0 = starts;
    repeat (50) @(posedge mclk);
    rd(2'h3, 4'h0, 16'(s0));
    rd(2'h0, 4'h0, res_of(4'h0, 2'h0));
    rd(2'h0, 4'h1, res_of(4'h1, 2'h0));
    wr(16'h3430);
    rd(2'h2, 4'h0, 16'h0034);
    wr(16'hc402);
    penDown <= 1'b1;
    repeat (50) @(posedge mclk);
    rd(2'h3, 4'h0, 16'(s0));
    rd(2'h2, 4'h0, 16'h0003);
    give_verdict();
  end
endmodule
bind tac_control tac_control_monitor mon (.mclk(mclk), .rst_n(rst_n),
  .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata), .ctrlRdata(ctrlRdata), .penDown(penDown),
  .adcStart(adcStart), .adcDone(adcDone), .adcPowerDown(adcPowerDown),
  .dataAvailable(dataAvailable));
`default_nettype wire
